// file: core/clk_divider.sv
/*
  recovered clock divider by 1, 2, 4 or 8 with unlock stop.
  assumes the recovery pll output arrives as a clock-rate enable pulse train.
*/
`timescale 1ns/100ps
module clk_divider
  import ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic pll_tick,
  input wire logic [1:0] div_sel,
  input wire logic run,
  output logic tick_out
);
  typedef struct packed {
    logic [2:0] cnt;
    logic out;
  } div_state_t;
  div_state_t st_reg;
  div_state_t st_next;
  logic [2:0] lim;
  always_comb begin
    lim = 3'((4'h1 << div_sel) - 4'h1);
    st_next = st_reg;
    st_next.out = 1'b0;
    if (run && pll_tick) begin
      if (st_reg.cnt >= lim) begin
        st_next.cnt = 3'h0;
        st_next.out = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 3'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign tick_out = st_reg.out;
  a_div_stop: assert property (@(posedge clk) disable iff (!nrst)
    !run |=> !tick_out)
    else $error("divided clock ran while stopped");
endmodule : clk_divider

// file: core/ctrl_pkg.sv
/*
  constants for the converter/transmitter event and receiver control register group.
  assumes a byte-wide register port driven by the serial host front end.
*/
// How it works
// - copy-done flag set when enabled, unmasked
// - transmitter flag pulls interrupt, sets summary bit
// - slip flag from slip or block start
// - ready flag when both estimators finish
// - ratio flag when input rate exceeds output
// - converter flags pull interrupt, set summary
// - status read-only, bits 5,4,1,0
// - mask bits enable interrupts, reset masked
// - two-bit trigger mode per interrupt
// - line select routes receiver 1 to 4
// - reference select: dedicated input or master
// - copy disable halts receive-to-host copying
// - output enable drives recovered clock pin
// - divider by 1, 2, 4, 8
// - auto-mute forces audio low on unlock
// - unlock mode stops or free-runs clock
// - control register 2 bit layout
// - control register 1 bit layout
package ctrl_pkg;
  localparam logic [7:0] OFF_STATUS = 8'h0A;
  localparam logic [7:0] OFF_MASK = 8'h0B;
  localparam logic [7:0] OFF_MODE = 8'h0C;
  localparam logic [7:0] OFF_RXCTL1 = 8'h0D;
  localparam logic [7:0] OFF_RXCTL2 = 8'h0E;
  localparam int BIT_COPY = 0;
  localparam int BIT_SLIP = 1;
  localparam int BIT_READY = 4;
  localparam int BIT_RATIO = 5;
  localparam int BIT_RX_COPY_DIS = 4;
  localparam int BIT_RX_REF = 3;
  localparam int BIT_RX_LINE = 0;
  localparam int BIT_UNLOCK_MODE = 4;
  localparam int BIT_AUTO_MUTE = 3;
  localparam int BIT_DIV = 1;
  localparam int BIT_CLK_OE = 0;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_RXCTL1 = 8'h00;
  localparam logic [7:0] RST_RXCTL2 = 8'h00;
  localparam logic [7:0] MASK_EVENTS = 8'h33;
  localparam logic [7:0] MASK_RXCTL1 = 8'h1B;
  localparam logic [7:0] MASK_RXCTL2 = 8'h1F;
  typedef enum logic [1:0] {
    TRIG_RISE = 2'h0,
    TRIG_FALL = 2'h1,
    TRIG_LEVEL = 2'h2,
    TRIG_RSVD = 2'h3
  } trig_t;
endpackage : ctrl_pkg

// file: core/ctrl_regs.sv
/*
  register group: converter/transmitter event status, mask and trigger mode,
  receiver control 1 and 2, with interrupt and receiver steering outputs.
  assumes the serial host front end issues one-cycle byte reads and writes.
*/
`timescale 1ns/100ps
module ctrl_regs
  import ctrl_pkg::*;
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  output logic RVALID,
  input wire logic TX_COPY_DONE,
  input wire logic TX_ASYNC_SLIP,
  input wire logic TX_BLOCK_START,
  input wire logic TRANSMIT_COPY_DISABLE,
  input wire logic SLIP_SOURCE_SELECT,
  input wire logic IN_EST_DONE,
  input wire logic OUT_EST_DONE,
  input wire logic RATE_IN_GT_OUT,
  input wire logic DECODER_UNLOCK,
  input wire logic RECOVERY_PLL_UNLOCK,
  input wire logic RECOVERY_PLL_TICK,
  input wire logic [3:0] LINE_RX,
  input wire logic [23:0] RX_AUDIO_IN,
  output logic INT_N_O,
  output logic INT_N_OE,
  output logic TX_SUMMARY,
  output logic CONV_SUMMARY,
  output logic RX_LINE_OUT,
  output logic [1:0] RECEIVER_LINE_SELECT,
  output logic RECEIVER_REF_SELECT,
  output logic RECEIVER_COPY_ENABLE,
  output logic RECOVERED_CLOCK_TICK,
  output logic RECOVERED_CLOCK_O,
  output logic RECOVERED_CLOCK_OE,
  output logic [23:0] RX_AUDIO_OUT
);
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] mode;
    logic [7:0] rxctl1;
    logic [7:0] rxctl2;
    logic [7:0] rdata;
    logic rvalid;
    logic line;
    logic [23:0] audio;
    logic ck_pin;
  } regs_t;
  regs_t st_reg;
  regs_t st_next;
  event_if ev ();
  logic div_tick;
  logic tx_copy_done_flag;
  logic tx_source_slip_flag;
  logic unlocked;
  logic [3:0] enabled;

  function automatic logic [7:0] read_mux(input logic [7:0] a, input regs_t s);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      OFF_STATUS: r = s.status & MASK_EVENTS;
      OFF_MASK: r = s.mask & MASK_EVENTS;
      OFF_MODE: r = s.mode;
      OFF_RXCTL1: r = s.rxctl1 & MASK_RXCTL1;
      OFF_RXCTL2: r = s.rxctl2 & MASK_RXCTL2;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : read_mux

  // raw event conditions in status bit order: copy, slip, ready, ratio
  assign ev.cond[0] = TX_COPY_DONE & ~TRANSMIT_COPY_DISABLE;
  assign ev.cond[1] = SLIP_SOURCE_SELECT ? TX_BLOCK_START : TX_ASYNC_SLIP;
  assign ev.cond[2] = IN_EST_DONE & OUT_EST_DONE;
  assign ev.cond[3] = RATE_IN_GT_OUT;
  assign ev.mode = st_reg.mode;
  assign enabled = {st_reg.mask[BIT_RATIO], st_reg.mask[BIT_READY],
                    st_reg.mask[BIT_SLIP], st_reg.mask[BIT_COPY]};

  trig_detect u_det (
    .clk(CLOCK),
    .nrst(NRST),
    .ev(ev)
  );

  assign unlocked = DECODER_UNLOCK & RECOVERY_PLL_UNLOCK;

  clk_divider u_div (
    .clk(CLOCK),
    .nrst(NRST),
    .pll_tick(RECOVERY_PLL_TICK),
    .div_sel(st_reg.rxctl2[BIT_DIV+1:BIT_DIV]),
    .run(~RECOVERY_PLL_UNLOCK | st_reg.rxctl2[BIT_UNLOCK_MODE]),
    .tick_out(div_tick)
  );

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = RD;
    if (RD) begin
      st_next.rdata = read_mux(ADDR, st_reg);
    end
    // flags stay set until the host reads status; a new hit beats the clear
    if (RD && ADDR == OFF_STATUS) begin
      st_next.status = 8'h00;
    end
    if (ev.hit[0] && enabled[0]) begin
      st_next.status[BIT_COPY] = 1'b1;
    end
    if (ev.hit[1] && enabled[1]) begin
      st_next.status[BIT_SLIP] = 1'b1;
    end
    if (ev.hit[2] && enabled[2]) begin
      st_next.status[BIT_READY] = 1'b1;
    end
    if (ev.hit[3] && enabled[3]) begin
      st_next.status[BIT_RATIO] = 1'b1;
    end
    if (WR) begin
      unique case (ADDR)
        OFF_MASK: st_next.mask = WDATA & MASK_EVENTS;
        OFF_MODE: st_next.mode = WDATA;
        OFF_RXCTL1: st_next.rxctl1 = WDATA & MASK_RXCTL1;
        OFF_RXCTL2: st_next.rxctl2 = WDATA & MASK_RXCTL2;
        // status and unmapped offsets ignore writes
        default: ;
      endcase
    end
    st_next.line = LINE_RX[st_reg.rxctl1[BIT_RX_LINE+1:BIT_RX_LINE]];
    // mute only when both decoder and pll agree lock is lost
    if (st_reg.rxctl2[BIT_AUTO_MUTE] && unlocked) begin
      st_next.audio = 24'h000000;
    end else begin
      st_next.audio = RX_AUDIO_IN;
    end
    st_next.ck_pin = div_tick;
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st_reg <= '0;
      st_reg.mask <= RST_MASK;
      st_reg.mode <= RST_MODE;
      st_reg.rxctl1 <= RST_RXCTL1;
      st_reg.rxctl2 <= RST_RXCTL2;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tx_copy_done_flag = st_reg.status[BIT_COPY];
  assign tx_source_slip_flag = st_reg.status[BIT_SLIP];
  assign TX_SUMMARY = tx_copy_done_flag | tx_source_slip_flag;
  assign CONV_SUMMARY = st_reg.status[BIT_READY] | st_reg.status[BIT_RATIO];
  // open-drain: drive low only, never drive high
  assign INT_N_O = 1'b0;
  assign INT_N_OE = TX_SUMMARY | CONV_SUMMARY;
  assign RDATA = st_reg.rdata;
  assign RVALID = st_reg.rvalid;
  assign RX_LINE_OUT = st_reg.line;
  assign RECEIVER_LINE_SELECT = st_reg.rxctl1[BIT_RX_LINE+1:BIT_RX_LINE];
  assign RECEIVER_REF_SELECT = st_reg.rxctl1[BIT_RX_REF];
  assign RECEIVER_COPY_ENABLE = ~st_reg.rxctl1[BIT_RX_COPY_DIS];
  assign RECOVERED_CLOCK_TICK = div_tick;
  assign RECOVERED_CLOCK_O = st_reg.ck_pin;
  assign RECOVERED_CLOCK_OE = st_reg.rxctl2[BIT_CLK_OE];
  assign RX_AUDIO_OUT = st_reg.audio;

  a_copy_flag_set: assert property (@(posedge CLOCK) disable iff (!NRST)
    (ev.hit[0] && enabled[0]) |=> st_reg.status[BIT_COPY])
    else $error("copy flag not set");
  a_tx_int_low: assert property (@(posedge CLOCK) disable iff (!NRST)
    (tx_copy_done_flag || tx_source_slip_flag) |-> (INT_N_OE && !INT_N_O && TX_SUMMARY))
    else $error("tx flag without interrupt");
  a_slip_flag_set: assert property (@(posedge CLOCK) disable iff (!NRST)
    (ev.hit[1] && enabled[1]) |=> st_reg.status[BIT_SLIP])
    else $error("slip flag not set");
  a_ready_flag_set: assert property (@(posedge CLOCK) disable iff (!NRST)
    (ev.hit[2] && enabled[2]) |=> st_reg.status[BIT_READY])
    else $error("ready flag not set");
  a_ratio_flag_set: assert property (@(posedge CLOCK) disable iff (!NRST)
    (ev.hit[3] && enabled[3]) |=> st_reg.status[BIT_RATIO])
    else $error("ratio flag not set");
  a_conv_int_low: assert property (@(posedge CLOCK) disable iff (!NRST)
    (st_reg.status[BIT_READY] || st_reg.status[BIT_RATIO]) |-> (INT_N_OE && CONV_SUMMARY))
    else $error("converter flag without interrupt");
  a_status_zeros: assert property (@(posedge CLOCK) disable iff (!NRST)
    (RD && ADDR == OFF_STATUS) |=> (RDATA & ~MASK_EVENTS) == 8'h00)
    else $error("reserved status bits nonzero");
  a_masked_quiet: assert property (@(posedge CLOCK) disable iff (!NRST)
    (!enabled[3] && !st_reg.status[BIT_RATIO] && !(RD && ADDR == OFF_STATUS)) |=>
      !st_reg.status[BIT_RATIO])
    else $error("masked ratio flag set");
  a_mute_zero: assert property (@(posedge CLOCK) disable iff (!NRST)
    (st_reg.rxctl2[BIT_AUTO_MUTE] && unlocked) |=> RX_AUDIO_OUT == 24'h000000)
    else $error("audio not muted on unlock");
  a_clk_hiz: assert property (@(posedge CLOCK) disable iff (!NRST)
    !st_reg.rxctl2[BIT_CLK_OE] |-> !RECOVERED_CLOCK_OE)
    else $error("recovered clock driven while disabled");
endmodule : ctrl_regs

// file: core/event_if.sv
/*
  event bundle between the register top and the trigger detector.
  assumes one clock domain.
*/
`timescale 1ns/100ps
interface event_if;
  logic [3:0] cond;
  logic [7:0] mode;
  logic [3:0] hit;
  modport top (output cond, output mode, input hit);
  modport det (input cond, input mode, output hit);
endinterface : event_if

// file: core/trig_detect.sv
/*
  per-event trigger detector: rising, falling or level.
  assumes conditions are synchronous to CLOCK.
*/
`timescale 1ns/100ps
module trig_detect
  import ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  event_if.det ev
);
  typedef struct packed {
    logic [3:0] prev;
  } det_state_t;
  det_state_t st_reg;
  det_state_t st_next;
  always_comb begin
    st_next.prev = ev.cond;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ev
      logic [1:0] m;
      assign m = ev.mode[2*g+1:2*g];
      // reserved code never triggers
      assign ev.hit[g] = (m == TRIG_RISE) ? (ev.cond[g] & ~st_reg.prev[g]) :
                         (m == TRIG_FALL) ? (~ev.cond[g] & st_reg.prev[g]) :
                         (m == TRIG_LEVEL) ? ev.cond[g] : 1'b0;
      a_rise_hit: assert property (@(posedge clk) disable iff (!nrst)
        (m == TRIG_RISE && $rose(ev.cond[g])) |-> ev.hit[g])
        else $error("rising edge not detected");
      a_level_hit: assert property (@(posedge clk) disable iff (!nrst)
        (m == TRIG_LEVEL) |-> (ev.hit[g] == ev.cond[g]))
        else $error("level mode mismatch");
    end
  endgenerate
endmodule : trig_detect

// file: tb/host_model.sv
/*
  host model: single-byte register writes and reads on the strobe port.
  assumes strobes are taken at the rising edge and read data answers a cycle later.
*/
`timescale 1ns/100ps
module host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output logic [7:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata
);
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // released lines show the inverse so stale values cannot pass
    addr <= ~a;
    wdata <= ~d;
  endtask : write
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    n = 0;
    #1;
    while (rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    ok = (rvalid === 1'b1);
    d = rdata;
  endtask : read
endmodule : host_model

// file: tb/test_converter_tx_irq_and_receiver_ctrl.sv
/*
  bench for the event and receiver control register group.
  assumes ctrl_regs ports and the host model strobe timing.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module test_converter_tx_irq_and_receiver_ctrl;
  import ctrl_pkg::*;
  logic CLOCK = 1'b0, NRST = 1'b0, TRANSMIT_COPY_DISABLE = 1'b0, SLIP_SOURCE_SELECT = 1'b0;
  logic DECODER_UNLOCK = 1'b0, RECOVERY_PLL_UNLOCK = 1'b0, RECOVERY_PLL_TICK = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [3:0] LINE_RX = 4'h0;
  logic [23:0] RX_AUDIO_IN = 24'hABCDEF;
  wire logic TX_COPY_DONE, TX_ASYNC_SLIP, TX_BLOCK_START, IN_EST_DONE, OUT_EST_DONE;
  wire logic RATE_IN_GT_OUT;
  logic [7:0] ADDR, WDATA, RDATA, d;
  logic WR, RD, RVALID, INT_N_O, INT_N_OE, TX_SUMMARY, CONV_SUMMARY, RX_LINE_OUT, ok;
  logic RECEIVER_REF_SELECT, RECEIVER_COPY_ENABLE, RECOVERED_CLOCK_TICK;
  logic RECOVERED_CLOCK_O, RECOVERED_CLOCK_OE;
  logic [1:0] RECEIVER_LINE_SELECT;
  logic [23:0] RX_AUDIO_OUT;
  int fails = 0, num_checks = 0, cnt;
  logic [7:0] regs [6] = '{OFF_STATUS, OFF_MASK, OFF_MODE, OFF_RXCTL1, OFF_RXCTL2, 8'h3F};
  logic [5:0] evs [5] = '{6'h01, 6'h02, 6'h04, 6'h18, 6'h20};
  logic [7:0] sts [5] = '{8'h01, 8'h02, 8'h02, 8'h10, 8'h20};
  assign {RATE_IN_GT_OUT, OUT_EST_DONE, IN_EST_DONE, TX_BLOCK_START, TX_ASYNC_SLIP,
    TX_COPY_DONE} = ev;
  always #12.5 CLOCK = ~CLOCK;
  // pll pulses every other cycle keep each divider count exact over 64 cycles
  always @(posedge CLOCK) RECOVERY_PLL_TICK <= NRST & ~RECOVERY_PLL_TICK;
  host_model u_host_model (.clk(CLOCK), .rdata(RDATA), .rvalid(RVALID), .addr(ADDR),
    .wr(WR), .rd(RD), .wdata(WDATA));
  ctrl_regs u_ctrl_regs (.CLOCK, .NRST, .ADDR, .WR, .RD, .WDATA, .RDATA, .RVALID,
    .TX_COPY_DONE, .TX_ASYNC_SLIP, .TX_BLOCK_START, .TRANSMIT_COPY_DISABLE,
    .SLIP_SOURCE_SELECT, .IN_EST_DONE, .OUT_EST_DONE, .RATE_IN_GT_OUT, .DECODER_UNLOCK,
    .RECOVERY_PLL_UNLOCK, .RECOVERY_PLL_TICK, .LINE_RX, .RX_AUDIO_IN, .INT_N_O,
    .INT_N_OE, .TX_SUMMARY, .CONV_SUMMARY, .RX_LINE_OUT, .RECEIVER_LINE_SELECT,
    .RECEIVER_REF_SELECT, .RECEIVER_COPY_ENABLE, .RECOVERED_CLOCK_TICK,
    .RECOVERED_CLOCK_O, .RECOVERED_CLOCK_OE, .RX_AUDIO_OUT);
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic w(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : w
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_host_model.write(a, v);
  endtask : wr
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    u_host_model.read(a, d, ok);
    if (ok !== 1'b1) begin
      fails++;
      final_report();
    end
    else `CHK(n, e, d)
  endtask : rd_chk
  task automatic pulse(input logic [5:0] m);
    @(posedge CLOCK) ev <= m;
    @(posedge CLOCK) ev <= 6'h00;
    w(2);
  endtask : pulse
  task automatic ticks(input logic [7:0] v, input int e);
    int co;
    wr(OFF_RXCTL2, v);
    w(16);
    cnt = 0;
    co = 0;
    repeat (64) begin
      w(1);
      cnt += (RECOVERED_CLOCK_TICK === 1'b1);
      co += (RECOVERED_CLOCK_O === 1'b1);
    end
    `CHK("ticks", e, cnt)
    `CHK("pin_ticks", e, co)
  endtask : ticks
  initial begin
    repeat (20) @(posedge CLOCK);
    NRST <= 1'b1;
    foreach (regs[i]) rd_chk("reset", regs[i], 8'h00);
    `CHK("copy_en", 1'b1, RECEIVER_COPY_ENABLE)
    `CHK("clk_oe", 1'b0, RECOVERED_CLOCK_OE)
    wr(OFF_RXCTL1, 8'hFF);
    rd_chk("rxctl1", OFF_RXCTL1, 8'h1B);
    `CHK("ref_sel", 1'b1, RECEIVER_REF_SELECT)
    `CHK("copy_en", 1'b0, RECEIVER_COPY_ENABLE)
    wr(OFF_RXCTL2, 8'hFF);
    rd_chk("rxctl2", OFF_RXCTL2, 8'h1F);
    `CHK("clk_oe", 1'b1, RECOVERED_CLOCK_OE)
    wr(OFF_STATUS, 8'hFF);
    rd_chk("status_ro", OFF_STATUS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_RXCTL1, 8'(i));
      @(posedge CLOCK) LINE_RX <= 4'h1 << i;
      w(3);
      `CHK("line_sel", 2'(i), RECEIVER_LINE_SELECT)
      `CHK("line_hi", 1'b1, RX_LINE_OUT)
      @(posedge CLOCK) LINE_RX <= ~(4'h1 << i);
      w(3);
      `CHK("line_lo", 1'b0, RX_LINE_OUT)
    end
    // line select set back to receiver 1 before the event checks
    wr(OFF_RXCTL1, 8'h00);
    wr(OFF_MASK, 8'hFF);
    rd_chk("mask", OFF_MASK, 8'h33);
    foreach (evs[i]) begin
      @(posedge CLOCK) SLIP_SOURCE_SELECT <= (i == 2);
      pulse(evs[i]);
      `CHK("int_oe", 1'b1, INT_N_OE)
      `CHK("int_o", 1'b0, INT_N_O)
      `CHK("tx_sum", i < 3, TX_SUMMARY)
      `CHK("conv_sum", i > 2, CONV_SUMMARY)
      rd_chk("flag", OFF_STATUS, sts[i]);
      rd_chk("cleared", OFF_STATUS, 8'h00);
      `CHK("int_off", 1'b0, INT_N_OE)
    end
    pulse(6'h08);
    rd_chk("one_est", OFF_STATUS, 8'h00);
    @(posedge CLOCK) TRANSMIT_COPY_DISABLE <= 1'b1;
    pulse(6'h01);
    rd_chk("copy_dis", OFF_STATUS, 8'h00);
    @(posedge CLOCK) TRANSMIT_COPY_DISABLE <= 1'b0;
    wr(OFF_MASK, 8'h00);
    pulse(6'h21);
    rd_chk("masked", OFF_STATUS, 8'h00);
    wr(OFF_MASK, 8'h33);
    wr(OFF_MODE, 8'h01);
    @(posedge CLOCK) ev <= 6'h01;
    w(3);
    rd_chk("fall_rise", OFF_STATUS, 8'h00);
    @(posedge CLOCK) ev <= 6'h00;
    w(3);
    rd_chk("fall", OFF_STATUS, 8'h01);
    wr(OFF_MODE, 8'h02);
    @(posedge CLOCK) ev <= 6'h01;
    w(2);
    rd_chk("level1", OFF_STATUS, 8'h01);
    rd_chk("level2", OFF_STATUS, 8'h01);
    @(posedge CLOCK) ev <= 6'h00;
    w(2);
    rd_chk("level3", OFF_STATUS, 8'h01);
    rd_chk("level4", OFF_STATUS, 8'h00);
    wr(OFF_MODE, 8'h03);
    pulse(6'h01);
    rd_chk("reserved", OFF_STATUS, 8'h00);
    // falling mode on the three upper fields checks their bit placement
    wr(OFF_MODE, 8'h54);
    rd_chk("mode", OFF_MODE, 8'h54);
    pulse(6'h3A);
    rd_chk("upper_fall", OFF_STATUS, 8'h32);
    wr(OFF_RXCTL2, 8'h08);
    @(posedge CLOCK) {DECODER_UNLOCK, RECOVERY_PLL_UNLOCK} <= 2'h3;
    w(3);
    `CHK("muted", 24'h000000, RX_AUDIO_OUT)
    @(posedge CLOCK) DECODER_UNLOCK <= 1'b0;
    w(3);
    `CHK("unmuted", 24'hABCDEF, RX_AUDIO_OUT)
    ticks(8'h10, 32);
    ticks(8'h00, 0);
    @(posedge CLOCK) RECOVERY_PLL_UNLOCK <= 1'b0;
    for (int i = 0; i < 4; i++) ticks(8'(i << 1), 32 >> i);
    final_report();
  end
endmodule : test_converter_tx_irq_and_receiver_ctrl
